// *** src/mcdbg_ctrl.sv ***
`timescale 1ns/10ps
`include "mcdbg_regs.svh"
// Controller end: drives halt/run handshakes and the reset-start select,
// and synchronises the core's status lines into its own clock.
module mcdbg_ctrl
	import mcdbg_pkg::*;
#(
	parameter int SYNC_STAGES = `MCDBG_SYNC_STAGES,
	parameter logic [15:0] ACK_TIMEOUT = `MCDBG_ACK_TIMEOUT
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic halt_cmd_in,
	input wire logic run_cmd_in,
	input wire logic start_halted_in,
	input wire logic halt_ack_in,
	input wire logic run_ack_in,
	input wire logic mode_status_in,
	input wire logic brkpt_status_in,
	output logic halt_req_out,
	output logic run_req_out,
	output logic reset_run_out,
	output logic busy_out,
	output logic done_out,
	output logic timeout_out,
	output logic core_halted_out,
	output logic core_brkpt_out
);
	// ==========================================================
	// Synchronisers for core outputs
	logic [SYNC_STAGES-1:0] sync [4];
	core_status_t st;
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_sync
			always_ff @(posedge clk_in) begin
				if (rst_in) begin
					sync[g] <= '0;
				end else begin
					sync[g] <= {sync[g][SYNC_STAGES-2:0],
						(g == 0) ? halt_ack_in :
						(g == 1) ? run_ack_in :
						(g == 2) ? mode_status_in : brkpt_status_in};
				end
			end
		end
	endgenerate
	assign st = '{halt_ack: sync[0][SYNC_STAGES-1],
		run_ack: sync[1][SYNC_STAGES-1],
		mode: sync[2][SYNC_STAGES-1],
		brkpt: sync[3][SYNC_STAGES-1]};

	// ==========================================================
	// Handshake sequencer
	hs_state_t state;
	core_req_t req;
	logic last_was_halt;
	logic [15:0] wait_cnt;
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state <= ST_IDLE;
			req <= '0;
			// Start as running, so a halt must come first unless reset_run_out has been lowered
			last_was_halt <= 1'b0;
			done_out <= 1'b0;
			timeout_out <= 1'b0;
			wait_cnt <= '0;
		end else begin
			done_out <= 1'b0;
			timeout_out <= 1'b0;
			case (state)
				ST_IDLE: begin
					wait_cnt <= '0;
					// Alternation avoids back-to-back halts, and back-to-back runs while reset_run_out is high
					if (halt_cmd_in && !last_was_halt) begin
						req.halt_req <= 1'b1;
						state <= ST_HALT_REQ;
					end else if (run_cmd_in
						&& (last_was_halt || !reset_run_out)) begin
						req.run_req <= 1'b1;
						state <= ST_RUN_REQ;
					end
				end
				ST_HALT_REQ: begin
					wait_cnt <= wait_cnt + 16'h0001;
					if (st.halt_ack) begin
						req.halt_req <= 1'b0;
						state <= ST_HALT_DROP;
					end else if (wait_cnt == ACK_TIMEOUT) begin
						timeout_out <= 1'b1;
					end
				end
				ST_HALT_DROP: begin
					if (!st.halt_ack) begin
						last_was_halt <= 1'b1;
						done_out <= 1'b1;
						state <= ST_IDLE;
					end
				end
				ST_RUN_REQ: begin
					// Ack may lag a debugger or power-manager halt, so no abort
					wait_cnt <= wait_cnt + 16'h0001;
					if (st.run_ack) begin
						req.run_req <= 1'b0;
						state <= ST_RUN_DROP;
					end else if (wait_cnt == ACK_TIMEOUT) begin
						timeout_out <= 1'b1;
					end
				end
				ST_RUN_DROP: begin
					if (!st.run_ack) begin
						last_was_halt <= 1'b0;
						done_out <= 1'b1;
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
					req <= '0;
				end
			endcase
		end
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			reset_run_out <= 1'b1;
		end else if (state == ST_RUN_DROP && !st.run_ack) begin
			reset_run_out <= 1'b1;
		end else if (state == ST_IDLE && start_halted_in && !last_was_halt
			&& reset_run_out && !halt_cmd_in && !run_cmd_in && !busy_out) begin
			// Next core reset starts halted until a run completes
			reset_run_out <= 1'b0;
		end
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			// Reset values match the tie-offs of an unconnected controller
			halt_req_out <= 1'b0;
			run_req_out <= 1'b0;
			busy_out <= 1'b0;
			core_halted_out <= 1'b0;
			core_brkpt_out <= 1'b0;
		end else begin
			halt_req_out <= req.halt_req;
			run_req_out <= req.run_req;
			busy_out <= (state != ST_IDLE);
			core_halted_out <= st.mode;
			core_brkpt_out <= st.brkpt;
		end
	end

	// ==========================================================
	// Checks
	// A request must outlive the core's ack path, so it stands two edges
	sequence s_halt_up;
		halt_req_out ##1 halt_req_out;
	endsequence

	sequence s_run_up;
		run_req_out ##1 run_req_out;
	endsequence

	property p_no_both;
		@(posedge clk_in) disable iff (rst_in)
			!(halt_req_out && run_req_out);
	endproperty
	a_no_both: assert property (p_no_both)
		else $error("halt and run together");

	property p_halt_hold;
		@(posedge clk_in) disable iff (rst_in)
			(state == ST_HALT_REQ && !st.halt_ack) |=> req.halt_req;
	endproperty
	a_halt_hold: assert property (p_halt_hold)
		else $error("halt req dropped early");

	property p_halt_drop;
		@(posedge clk_in) disable iff (rst_in)
			(state == ST_HALT_REQ && st.halt_ack) |-> ##2 !halt_req_out;
	endproperty
	a_halt_drop: assert property (p_halt_drop)
		else $error("halt req not dropped");

	property p_halt_drop_wait;
		@(posedge clk_in) disable iff (rst_in)
			(state == ST_HALT_DROP && st.halt_ack) |=> state == ST_HALT_DROP;
	endproperty
	a_halt_drop_wait: assert property (p_halt_drop_wait)
		else $error("halt handshake closed before ack fell");

	property p_run_hold;
		@(posedge clk_in) disable iff (rst_in)
			(state == ST_RUN_REQ && !st.run_ack) |=> req.run_req;
	endproperty
	a_run_hold: assert property (p_run_hold)
		else $error("run req dropped early");

	property p_run_drop;
		@(posedge clk_in) disable iff (rst_in)
			(state == ST_RUN_REQ && st.run_ack) |-> ##2 !run_req_out;
	endproperty
	a_run_drop: assert property (p_run_drop)
		else $error("run req not dropped");

	property p_run_drop_wait;
		@(posedge clk_in) disable iff (rst_in)
			(state == ST_RUN_DROP && st.run_ack) |=> state == ST_RUN_DROP;
	endproperty
	a_run_drop_wait: assert property (p_run_drop_wait)
		else $error("run handshake closed before ack fell");

	property p_done_clean;
		@(posedge clk_in) disable iff (rst_in)
			done_out |-> (!halt_req_out && !run_req_out);
	endproperty
	a_done_clean: assert property (p_done_clean)
		else $error("done while a request stands");

	property p_no_double_halt;
		@(posedge clk_in) disable iff (rst_in)
			$rose(halt_req_out) |-> !$past(last_was_halt, 2);
	endproperty
	a_no_double_halt: assert property (p_no_double_halt)
		else $error("two halts");

	property p_halt_refused;
		@(posedge clk_in) disable iff (rst_in)
			(state == ST_IDLE && halt_cmd_in && last_was_halt)
			|=> !req.halt_req;
	endproperty
	a_halt_refused: assert property (p_halt_refused)
		else $error("repeated halt accepted");

	property p_no_double_run;
		@(posedge clk_in) disable iff (rst_in)
			(state == ST_IDLE && run_cmd_in && !last_was_halt
			&& reset_run_out) |=> !req.run_req;
	endproperty
	a_no_double_run: assert property (p_no_double_run)
		else $error("two runs");

	property p_halt_rise;
		@(posedge clk_in) disable iff (rst_in)
			(state == ST_IDLE && halt_cmd_in && !last_was_halt)
			|-> ##2 s_halt_up;
	endproperty
	a_halt_rise: assert property (p_halt_rise)
		else $error("halt req missing");

	property p_run_rise;
		@(posedge clk_in) disable iff (rst_in)
			(state == ST_IDLE && run_cmd_in
			&& !(halt_cmd_in && !last_was_halt)
			&& (last_was_halt || !reset_run_out)) |-> ##2 s_run_up;
	endproperty
	a_run_rise: assert property (p_run_rise)
		else $error("run req missing");

	property p_start_sel;
		@(posedge clk_in) disable iff (rst_in)
			(state == ST_IDLE && start_halted_in && !last_was_halt
			&& reset_run_out && !halt_cmd_in && !run_cmd_in && !busy_out)
			|=> !reset_run_out;
	endproperty
	a_start_sel: assert property (p_start_sel)
		else $error("start select not lowered");

	property p_start_restore;
		@(posedge clk_in) disable iff (rst_in)
			(state == ST_RUN_DROP && !st.run_ack)
			|=> (reset_run_out && state == ST_IDLE);
	endproperty
	a_start_restore: assert property (p_start_restore)
		else $error("start select not restored");

	// Release of reset must leave the tie-off levels on the core pins
	property p_reset_idle;
		@(posedge clk_in) disable iff (rst_in)
			$fell(rst_in)
			|-> (!halt_req_out && !run_req_out && reset_run_out && !busy_out);
	endproperty
	a_reset_idle: assert property (p_reset_idle)
		else $error("outputs not idle after reset");

	property p_mode_follow;
		@(posedge clk_in) disable iff (rst_in)
			st.mode |=> core_halted_out;
	endproperty
	a_mode_follow: assert property (p_mode_follow)
		else $error("mode not shown");

	property p_mode_clear;
		@(posedge clk_in) disable iff (rst_in)
			!st.mode |=> !core_halted_out;
	endproperty
	a_mode_clear: assert property (p_mode_clear)
		else $error("mode shown after exit");

	property p_brk_follow;
		@(posedge clk_in) disable iff (rst_in)
			st.brkpt |=> core_brkpt_out;
	endproperty
	a_brk_follow: assert property (p_brk_follow)
		else $error("breakpoint not shown");

	property p_brk_clear;
		@(posedge clk_in) disable iff (rst_in)
			!st.brkpt |=> !core_brkpt_out;
	endproperty
	a_brk_clear: assert property (p_brk_clear)
		else $error("breakpoint shown after clear");

	// A late ack only raises a flag; the request must still be up
	property p_timeout_state;
		@(posedge clk_in) disable iff (rst_in)
			timeout_out |-> (state == ST_HALT_REQ || state == ST_RUN_REQ);
	endproperty
	a_timeout_state: assert property (p_timeout_state)
		else $error("timeout outside a request");

	property p_timeout_req;
		@(posedge clk_in) disable iff (rst_in)
			timeout_out |-> (halt_req_out || run_req_out);
	endproperty
	a_timeout_req: assert property (p_timeout_req)
		else $error("request aborted on timeout");
endmodule : mcdbg_ctrl

// *** src/mcdbg_pkg.sv ***
package mcdbg_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_HALT_REQ = 3'b001,
		ST_HALT_DROP = 3'b010,
		ST_RUN_REQ = 3'b011,
		ST_RUN_DROP = 3'b100
	} hs_state_t;
	typedef struct packed {
		logic halt_ack;
		logic run_ack;
		logic mode;
		logic brkpt;
	} core_status_t;
	typedef struct packed {
		logic halt_req;
		logic run_req;
	} core_req_t;
endpackage : mcdbg_pkg

// *** src/mcdbg_regs.svh ***
`ifndef MCDBG_REGS_SVH
`define MCDBG_REGS_SVH
`define MCDBG_CAUSE_HALTREQ 3'h3
`define MCDBG_SYNC_STAGES 2
`define MCDBG_ACK_TIMEOUT 16'h03E8
`endif

// *** verif/core_model.sv ***
`timescale 1ns/10ps
`include "mcdbg_regs.svh"
// ==================================================
// Core stand-in: acks lat_in + 1 cycles after a request, holds acks while requests stand
module core_model (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic halt_req_in,
	input wire logic run_req_in,
	input wire logic brk_in,
	input wire logic [4:0] lat_in,
	output logic halt_ack_out,
	output logic run_ack_out,
	output logic mode_out,
	output logic brkpt_out
);
	logic [4:0] cnt;
	logic [2:0] cause;
	logic [15:0] pc;
	logic [15:0] dpc;
	// Debug entry bookkeeping, kept apart from the handshake
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			cause <= 3'h0;
			pc <= 16'h0000;
			dpc <= 16'h0000;
		end else begin
			if (!mode_out) pc <= pc + 16'h0004;
			if (halt_req_in && !halt_ack_out && cnt == lat_in) begin
				cause <= `MCDBG_CAUSE_HALTREQ;
				dpc <= pc;
			end
		end
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			{halt_ack_out, run_ack_out, mode_out, brkpt_out} <= 4'h0;
			cnt <= 5'h00;
		end else begin
			if (brk_in) begin
				mode_out <= 1'b1;
				brkpt_out <= 1'b1;
			end
			if (halt_req_in && !halt_ack_out) begin
				cnt <= cnt + 5'h01;
				if (cnt == lat_in) begin
					mode_out <= 1'b1;
					halt_ack_out <= 1'b1;
					cnt <= 5'h00;
				end
			end else if (!halt_req_in) halt_ack_out <= 1'b0;
			if (run_req_in && !run_ack_out) begin
				cnt <= cnt + 5'h01;
				// Latency stands in for debugger or power-manager delay
				if (cnt == lat_in) begin
					{mode_out, brkpt_out, run_ack_out} <= 3'h1;
					cnt <= 5'h00;
				end
			end else if (!run_req_in) run_ack_out <= 1'b0;
		end
	end
endmodule : core_model

// *** verif/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
	import mcdbg_pkg::*;
	logic clk_in, rst_in, hcmd, rcmd, shalt, brk;
	logic hreq, rreq, rrun, busy, done, tmo, chalt, cbrk;
	logic hack, rack, mode, brkpt, to;
	logic [4:0] lat;
	int n_mismatch = 0;
	int cmp_count = 0;
	mcdbg_ctrl #(.ACK_TIMEOUT(16'h0014)) uut (.clk_in(clk_in),
		.rst_in(rst_in), .halt_cmd_in(hcmd), .run_cmd_in(rcmd),
		.start_halted_in(shalt), .halt_ack_in(hack), .run_ack_in(rack),
		.mode_status_in(mode), .brkpt_status_in(brkpt),
		.halt_req_out(hreq), .run_req_out(rreq), .reset_run_out(rrun),
		.busy_out(busy), .done_out(done), .timeout_out(tmo),
		.core_halted_out(chalt), .core_brkpt_out(cbrk));
	core_model core (.clk_in(clk_in), .rst_in(rst_in), .halt_req_in(hreq),
		.run_req_in(rreq), .brk_in(brk), .lat_in(lat),
		.halt_ack_out(hack), .run_ack_out(rack), .mode_out(mode),
		.brkpt_out(brkpt));
	// ==================================================
	// Shared tasks
	task report_and_stop;
		if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : report_and_stop
	task chk(input string nm, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %b got %b", nm, e, g);
		end
	endtask : chk
	// One full handshake; to records whether a timeout flag was seen
	task hs(input logic h, input logic [4:0] l);
		int i;
		lat = l;
		@(negedge clk_in);
		hcmd = h;
		rcmd = !h;
		@(negedge clk_in);
		hcmd = 1'b0;
		rcmd = 1'b0;
		to = 1'b0;
		for (i = 0; i < 200 && done !== 1'b1; i++) begin
			@(negedge clk_in);
			if (tmo === 1'b1) to = 1'b1;
		end
		if (done !== 1'b1) begin
			n_mismatch++;
			report_and_stop;
		end
	endtask : hs
	// ==================================================
	// Scenarios
	task t_halt;
		chk("reset_run", 1'b1, rrun);
		hs(1'b1, 5'h00);
		chk("halted", 1'b1, chalt);
		chk("timeout", 1'b0, to);
		chk("halt_req", 1'b0, hreq);
	endtask : t_halt
	task t_refuse;
		@(negedge clk_in);
		hcmd = 1'b1;
		@(negedge clk_in);
		hcmd = 1'b0;
		repeat (6) @(negedge clk_in);
		chk("busy", 1'b0, busy);
		chk("halt_req", 1'b0, hreq);
	endtask : t_refuse
	task t_slow_run;
		hs(1'b0, 5'h19);
		chk("timeout", 1'b1, to);
		chk("halted", 1'b0, chalt);
		chk("run_req", 1'b0, rreq);
	endtask : t_slow_run
	task t_refuse_run;
		@(negedge clk_in);
		rcmd = 1'b1;
		@(negedge clk_in);
		rcmd = 1'b0;
		repeat (6) @(negedge clk_in);
		chk("busy", 1'b0, busy);
		chk("run_req", 1'b0, rreq);
	endtask : t_refuse_run
	task t_brk;
		@(negedge clk_in);
		brk = 1'b1;
		@(negedge clk_in);
		brk = 1'b0;
		repeat (6) @(negedge clk_in);
		chk("brkpt", 1'b1, cbrk);
		hs(1'b1, 5'h03);
		hs(1'b0, 5'h03);
		chk("brkpt", 1'b0, cbrk);
	endtask : t_brk
	task t_start;
		@(negedge clk_in);
		shalt = 1'b1;
		repeat (4) @(negedge clk_in);
		chk("reset_run", 1'b0, rrun);
		shalt = 1'b0;
		hs(1'b0, 5'h01);
		chk("reset_run", 1'b1, rrun);
	endtask : t_start
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	initial begin
		{rst_in, hcmd, rcmd, shalt, brk, lat} = {5'h10, 5'h00};
		repeat (2) @(negedge clk_in);
		rst_in = 1'b0;
		t_halt;
		t_refuse;
		t_slow_run;
		t_refuse_run;
		t_brk;
		t_start;
		report_and_stop;
	end
endmodule : tb_top
